// ---- cbd_drive.sv ----
`timescale 1ns/10ps
module cbd_drive #(
  parameter int LAMP_DIV = cbd_pkg::LAMP_DIV_DEF,
  parameter int STRIKE_DIV = cbd_pkg::STRIKE_DIV_DEF,
  parameter int DIM_TICK = cbd_pkg::DIM_TICK_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic lamp_current_sense,
  input wire logic lamp_current_low,
  input wire logic inverter_supply_high_monitor,
  input wire logic inverter_supply_low_monitor,
  input wire logic core_supply_lockout,
  input wire logic dimming_pulse_in,
  input wire logic dimSourceSel,
  input wire logic slopeSel,
  input wire logic [cbd_pkg::LW-1:0] brightness_level,
  output logic gate_drive_a,
  output logic gate_drive_b,
  output logic burstActive,
  output logic lampStruck
);
  import cbd_pkg::*;
  typedef struct packed {
    cbd_state_t state;
    logic [CW-1:0] phase;
    logic half;
    logic [CW-1:0] onTime;
    logic [CW-1:0] softCap;
    logic [CW-1:0] dimTick;
    logic [LW-1:0] dimCnt;
    logic burstPrev;
    logic gateA;
    logic gateB;
  } cbd_st_t;
  cbd_st_t st_r, st_nxt;
  cbd_sync_if sy();
  logic supplyOk;
  logic burst;
  logic [LW-1:0] level;
  logic [CW-1:0] period;
  logic [CW-1:0] onMax;
  logic [CW-1:0] onEff;
  logic cycleEnd;

  function automatic logic [CW-1:0] minOf(input logic [CW-1:0] a, input logic [CW-1:0] b);
    minOf = (a < b) ? a : b;
  endfunction

  // ****************
  // Input synchronizers
  // ****************
  cbd_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn({dimming_pulse_in, core_supply_lockout, inverter_supply_low_monitor,
              inverter_supply_high_monitor, lamp_current_sense}),
    .sy(sy)
  );

  // ****************
  // Supply qualification and burst source
  // ****************
  assign supplyOk = !sy.lockout && sy.svLow && !sy.svHigh;
  assign level = slopeSel ? (LEVEL_MAX - brightness_level) : brightness_level;
  assign burst = dimSourceSel ? sy.dimPulse : (st_r.dimCnt < level);
  assign period = (st_r.state == ST_STRIKE) ? CW'(STRIKE_DIV) : CW'(LAMP_DIV);
  assign onMax = (period >> 1) - ON_MIN;
  assign onEff = minOf(minOf(st_r.onTime, st_r.softCap), onMax);
  assign cycleEnd = st_r.phase >= ((period >> 1) - 16'h0001);

  // ****************
  // Next state
  // ****************
  always_comb begin
    st_nxt = st_r;
    st_nxt.burstPrev = burst;
    if (st_r.dimTick >= CW'(DIM_TICK - 1)) begin
      st_nxt.dimTick = '0;
      st_nxt.dimCnt = st_r.dimCnt + 8'h01;
    end else begin
      st_nxt.dimTick = st_r.dimTick + 16'h0001;
    end
    if (cycleEnd) begin
      st_nxt.phase = '0;
      st_nxt.half = !st_r.half;
      if (lamp_current_low && st_r.onTime < onMax) begin
        st_nxt.onTime = st_r.onTime + ON_STEP;
      end else if (!lamp_current_low && st_r.onTime > ON_MIN) begin
        st_nxt.onTime = st_r.onTime - ON_STEP;
      end
    end else begin
      st_nxt.phase = st_r.phase + 16'h0001;
    end
    unique case (st_r.state)
      ST_OFF: if (supplyOk) st_nxt.state = ST_STRIKE;
      ST_STRIKE: if (sy.curOk) st_nxt.state = ST_RUN;
      ST_RUN: ;
    endcase
    if (!supplyOk) begin
      st_nxt.state = ST_OFF;
    end
    st_nxt.gateA = 1'b0;
    st_nxt.gateB = 1'b0;
    if (supplyOk && st_r.state != ST_OFF && burst && st_r.phase < onEff) begin
      st_nxt.gateA = !st_r.half;
      st_nxt.gateB = st_r.half;
    end
    // Soft-start cap steps up once per finished pulse
    if ((st_r.gateA || st_r.gateB) && !(st_nxt.gateA || st_nxt.gateB)
        && st_r.softCap < onMax) begin
      st_nxt.softCap = st_r.softCap + SOFT_STEP;
    end
    // Cap rests at its floor outside a burst and on its first cycle
    if (!supplyOk || !burst || !st_r.burstPrev) begin
      st_nxt.softCap = ON_MIN;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: ST_OFF, onTime: ON_MIN, softCap: ON_MIN, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate_drive_a = st_r.gateA;
  assign gate_drive_b = st_r.gateB;
  assign burstActive = burst;
  assign lampStruck = st_r.state == ST_RUN;

  // ****************
  // Assertions
  // ****************
  property p_alt;
    @(posedge ref_clk) disable iff (!rst_n) !(gate_drive_a && gate_drive_b);
  endproperty
  a_alt: assert property (p_alt) else $error("both gates on");
  property p_burst_off;
    @(posedge ref_clk) disable iff (!rst_n) !burst |=> !gate_drive_a && !gate_drive_b;
  endproperty
  a_burst_off: assert property (p_burst_off) else $error("gate on outside burst");
  property p_supply_off;
    @(posedge ref_clk) disable iff (!rst_n) !supplyOk |=> !gate_drive_a && !gate_drive_b;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("gate on with bad supply");
  property p_lockout;
    @(posedge ref_clk) disable iff (!rst_n) sy.lockout |=> st_r.state == ST_OFF;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout ignored");
  property p_ext;
    @(posedge ref_clk) disable iff (!rst_n) dimSourceSel |-> burst == sy.dimPulse;
  endproperty
  a_ext: assert property (p_ext) else $error("external pulse not used");
  property p_strike_period;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == ST_STRIKE |-> period == CW'(STRIKE_DIV);
  endproperty
  a_strike_period: assert property (p_strike_period) else $error("no strike boost");
  property p_struck;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == ST_STRIKE && sy.curOk && supplyOk |=> st_r.state == ST_RUN;
  endproperty
  a_struck: assert property (p_struck) else $error("strike not ended");
  property p_soft;
    @(posedge ref_clk) disable iff (!rst_n) burst && !st_r.burstPrev |=> st_r.softCap == ON_MIN;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start missing");
  property p_slope;
    @(posedge ref_clk) disable iff (!rst_n)
      slopeSel |-> level == LEVEL_MAX - brightness_level;
  endproperty
  a_slope: assert property (p_slope) else $error("slope not inverted");
  property p_off_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == ST_OFF |=> !gate_drive_a && !gate_drive_b;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("gate on before start");
  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == ST_OFF && supplyOk |=> st_r.state == ST_STRIKE;
  endproperty
  a_start: assert property (p_start) else $error("strike not started");
  property p_run_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == ST_RUN && supplyOk |=> st_r.state == ST_RUN;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run phase left");
  property p_run_period;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.state == ST_RUN |-> period == CW'(LAMP_DIV);
  endproperty
  a_run_period: assert property (p_run_period) else $error("run not at lamp rate");
  property p_half_toggle;
    @(posedge ref_clk) disable iff (!rst_n)
      cycleEnd |=> st_r.phase == '0 && st_r.half != $past(st_r.half);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("half not toggled");
  property p_gate_a_half;
    @(posedge ref_clk) disable iff (!rst_n)
      gate_drive_a |-> !st_r.half;
  endproperty
  a_gate_a_half: assert property (p_gate_a_half) else $error("gate a in b half");
  property p_gate_b_half;
    @(posedge ref_clk) disable iff (!rst_n)
      gate_drive_b |-> st_r.half;
  endproperty
  a_gate_b_half: assert property (p_gate_b_half) else $error("gate b in a half");
  property p_soft_step;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.softCap > $past(st_r.softCap) |-> st_r.softCap == $past(st_r.softCap) + SOFT_STEP;
  endproperty
  a_soft_step: assert property (p_soft_step) else $error("soft start jumped");
  property p_on_step;
    @(posedge ref_clk) disable iff (!rst_n)
      st_r.onTime != $past(st_r.onTime) |->
        st_r.onTime == $past(st_r.onTime) + ON_STEP || st_r.onTime == $past(st_r.onTime) - ON_STEP;
  endproperty
  a_on_step: assert property (p_on_step) else $error("on-time jumped");
  property p_ext_off;
    @(posedge ref_clk) disable iff (!rst_n)
      dimSourceSel && !sy.dimPulse |=> !gate_drive_a && !gate_drive_b;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("gate on with pulse low");
  c_run: cover property (@(posedge ref_clk) disable iff (!rst_n) st_r.state == ST_RUN);
  c_strike: cover property (@(posedge ref_clk) disable iff (!rst_n) st_r.state == ST_STRIKE);
  c_gate_a: cover property (@(posedge ref_clk) disable iff (!rst_n) gate_drive_a);
  c_gate_b: cover property (@(posedge ref_clk) disable iff (!rst_n) gate_drive_b);
  c_burst: cover property (@(posedge ref_clk) disable iff (!rst_n) burst && !st_r.burstPrev);
endmodule

// ---- cbd_pkg.sv ----
// Functional notes
// - Gate outputs alternate; never both commanded on together.
// - On-time adjusts from lamp current compared against internal reference.
// - Burst gate high drives gates continuously at lamp frequency.
// - Burst gate low holds both gate outputs inactive.
// - Brightness set only by burst duty cycle within each dimming cycle.
// - Each burst starts with soft-start ramp of gate duty.
// - Source select low: duty from brightness level, frequency from dimming oscillator.
// - Slope select low gives positive mapping, high inverts it.
// - Source select high: external 80-300 Hz pulse is the burst gate directly.
// - During strike, lamp frequency raised by 33 percent.
// - After strike detected, frequency returns to normal.
// - High monitor means overvoltage, low monitor means undervoltage, 2 V threshold.
// - Drive stops when inverter supply above high or below low trip point.
// - Core supply lockout inhibits all lamp operation.
// - Core supply lockout has no override path.
// - Lamp current flow declares lamp struck, ending strike phase.
// - No drive until core supply, low and high monitors all acceptable.
package cbd_pkg;
  localparam int CLK_MHZ = 250;
  localparam int LAMP_HZ_DEF = 50000;
  localparam int DIM_HZ_DEF = 160;
  localparam int BOOST_PCT = 33;
  localparam int PCT_FULL = 100;
  localparam int LAMP_DIV_DEF = CLK_MHZ * 1000000 / LAMP_HZ_DEF;
  localparam int STRIKE_DIV_DEF = LAMP_DIV_DEF * PCT_FULL / (PCT_FULL + BOOST_PCT);
  localparam int DIM_STEPS = 256;
  localparam int DIM_TICK_DEF = CLK_MHZ * 1000000 / (DIM_HZ_DEF * DIM_STEPS);
  localparam int CW = 16;
  localparam int LW = 8;
  localparam logic [LW-1:0] LEVEL_MAX = 8'hff;
  localparam logic [CW-1:0] ON_MIN = 16'h0004;
  localparam logic [CW-1:0] ON_STEP = 16'h0001;
  localparam logic [CW-1:0] SOFT_STEP = 16'h0002;
  typedef enum logic [1:0] {ST_OFF, ST_STRIKE, ST_RUN} cbd_state_t;
endpackage

// ---- cbd_sync_if.sv ----
`timescale 1ns/10ps
interface cbd_sync_if;
  logic curOk;
  logic svHigh;
  logic svLow;
  logic lockout;
  logic dimPulse;
  modport src (output curOk, output svHigh, output svLow, output lockout, output dimPulse);
  modport dst (input curOk, input svHigh, input svLow, input lockout, input dimPulse);
endinterface

// ---- cbd_sync.sv ----
`timescale 1ns/10ps
module cbd_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] asyncIn,
  cbd_sync_if.src sy
);
  import cbd_pkg::*;
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
  } cbd_sync_st_t;
  cbd_sync_st_t st_r, st_nxt;
  // ****************
  // Two-stage synchronizer
  // ****************
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = asyncIn;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign sy.curOk = st_r.s2[0];
  assign sy.svHigh = st_r.s2[1];
  assign sy.svLow = st_r.s2[2];
  assign sy.lockout = st_r.s2[3];
  assign sy.dimPulse = st_r.s2[4];
  property p_sync_delay;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> st_r.s2 == $past(asyncIn, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync not two stages");
endmodule

// ---- cbd_gate_model.sv ----
`timescale 1ns/10ps
// ****************************************
// Gate stage and lamp model
// ****************************************
module cbd_gate_model #(
  parameter int TARGET = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gate_drive_a,
  input wire logic gate_drive_b,
  input wire logic canStrike,
  output logic lamp_current_sense,
  output logic lamp_current_low
);
  logic [7:0] idle_r, wid_r, last_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_r <= 8'hff;
      wid_r <= 8'h00;
      last_r <= 8'h00;
    end else if (gate_drive_a | gate_drive_b) begin
      idle_r <= 8'h00;
      wid_r <= wid_r + 8'h01;
    end else begin
      idle_r <= (idle_r == 8'hff) ? idle_r : idle_r + 8'h01;
      last_r <= (wid_r != 8'h00) ? wid_r : last_r;
      wid_r <= 8'h00;
    end
  end
  // Current flows while the lamp is lit and driven
  assign lamp_current_sense = canStrike && (idle_r < 8'h28);
  // Narrow pulses read as current below reference
  assign lamp_current_low = last_r < 8'(TARGET);
endmodule

// ---- ccfl_burst_dimming_drive_test.sv ----
`timescale 1ns/10ps
module ccfl_burst_dimming_drive_test;
  import cbd_pkg::*;
  localparam int LD = 40;
  localparam int SD = 30;
  localparam int DT = 4;
  localparam int TGT = 8;
  logic ref_clk = 1'b0;
  logic curSense, curLow, gateA, gateB, burst, struck;
  logic rst_n = 1'b0, lockout = 1'b1, dimPulse = 1'b1, srcSel = 1'b1;
  logic svHi = 1'b0, svLo = 1'b1;
  logic slopeSel = 1'b0, canStrike = 1'b0, quiet = 1'b1;
  logic armed = 1'b0, pa = 1'b0, pb = 1'b0;
  logic [7:0] level = 8'h00;
  logic [15:0] w, cnt = 16'h0000;
  logic [15:0] q[$];
  int errTotal = 0, numChecks = 0, seed = 64736, n, k;
  cbd_drive #(.LAMP_DIV(LD), .STRIKE_DIV(SD), .DIM_TICK(DT)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .lamp_current_sense(curSense),
    .lamp_current_low(curLow), .inverter_supply_high_monitor(svHi),
    .inverter_supply_low_monitor(svLo), .core_supply_lockout(lockout),
    .dimming_pulse_in(dimPulse), .dimSourceSel(srcSel), .slopeSel(slopeSel),
    .brightness_level(level), .gate_drive_a(gateA), .gate_drive_b(gateB),
    .burstActive(burst), .lampStruck(struck));
  cbd_gate_model #(.TARGET(TGT)) lamp (.ref_clk(ref_clk), .rst_n(rst_n),
    .gate_drive_a(gateA), .gate_drive_b(gateB), .canStrike(canStrike),
    .lamp_current_sense(curSense), .lamp_current_low(curLow));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Checks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task giveVerdict;
    $display("checks=%0d errors=%0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task hang;
    errTotal++;
    giveVerdict();
  endtask
  task step(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task width(output logic [15:0] wd);
    wd = 16'h0000;
    for (n = 0; n < 200 && (gateA | gateB); n++) @(negedge ref_clk);
    if (n == 200) hang();
    for (n = 0; n < 200 && !(gateA | gateB); n++) @(negedge ref_clk);
    if (n == 200) hang();
    while ((gateA | gateB) && wd < 16'd200) begin
      wd++;
      @(negedge ref_clk);
    end
    step(1);
  endtask
  always @(negedge ref_clk) begin
    check(16'(gateA & gateB), 16'h0000);
    if (quiet || (!burst && !pb)) check({14'h0, gateA, gateB}, 16'h0000);
    cnt = cnt + 16'h0001;
    if (gateA && !pa) begin
      if (q.size() > 0 && armed) begin
        check(cnt, q.pop_front());
        armed = 1'b0;
      end else if (q.size() > 0) armed = 1'b1;
      cnt = 16'h0000;
    end
    pa = gateA;
    pb = burst;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    hang();
  end
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    step(3);
    rst_n = 1'b1;
    step(60);
    check(16'(struck), 16'h0000);
    lockout = 1'b0;
    quiet = 1'b0;
    q.push_back(16'(SD));
    for (n = 0; n < 300 && q.size() > 0; n++) step(1);
    if (n == 300) hang();
    canStrike = 1'b1;
    for (n = 0; n < 300 && !struck; n++) step(1);
    if (n == 300) hang();
    q.push_back(16'(LD));
    for (n = 0; n < 300 && q.size() > 0; n++) step(1);
    if (n == 300) hang();
    step(400);
    width(w);
    check(16'(w >= TGT - 2 && w <= TGT + 2), 16'h0001);
    dimPulse = 1'b0;
    step(4);
    quiet = 1'b1;
    step(100);
    check(16'(burst), 16'h0000);
    quiet = 1'b0;
    dimPulse = 1'b1;
    width(w);
    check(16'(w <= ON_MIN), 16'h0001);
    for (k = 0; k < 2; k++) begin
      svHi = ~k[0];
      svLo = ~k[0];
      step(4);
      quiet = 1'b1;
      step(50);
      check(16'(struck), 16'h0000);
      svHi = 1'b0;
      svLo = 1'b1;
      quiet = 1'b0;
      step(200);
    end
    srcSel = 1'b0;
    for (k = 0; k < 4; k++) begin
      step(1);
      level = (k == 0) ? 8'h00 : 8'($random(seed));
      slopeSel = k[0];
      step(8);
      w = 16'h0000;
      for (n = 0; n < 256 * DT; n++) begin
        @(negedge ref_clk);
        w = w + 16'(burst);
      end
      check(w, 16'((slopeSel ? LEVEL_MAX - level : level) * DT));
    end
    giveVerdict();
  end
endmodule
